// >>> hw/eeprom_pkg.sv
// Shared constants for the two-wire EEPROM slave and its programming engine
package eeprom_pkg;
    localparam int BYTE_W = 8;
    localparam int MEM_ADDR_W = 9;
    localparam int MEM_DEPTH = 512;
    localparam int PAGE_BYTES = 16;
    localparam int NIBBLE_W = 4;
    localparam int PAGE_SEL_W = MEM_ADDR_W - NIBBLE_W;
    localparam int SEL_FIELD_MSB = 7;
    localparam int SEL_FIELD_LSB = 2;
    localparam int SEL_PAGE_BIT = 1;
    localparam int SEL_DIR_BIT = 0;
    localparam logic [5:0] FIXED_DEVICE_ADDRESS_FIELD = 6'h28;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_ONE = 4'h1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] NIBBLE_ONE = 4'h1;
    // Programming time is not given; a plain default, in nanoseconds
    localparam int PROG_TIME_NS = 4000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 20;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 20'h00000;
endpackage

// >>> hw/prog_if.sv
// Carrier between the link front end and the programming engine
interface prog_if;
    import eeprom_pkg::*;
    logic wordValid;
    logic wordFirst;
    logic [MEM_ADDR_W-1:0] wordAddr;
    logic [BYTE_W-1:0] wordData;
    logic commit;
    logic busy;
    logic [MEM_ADDR_W-1:0] peekAddr;
    logic [BYTE_W-1:0] peekData;
    modport front (output wordValid, output wordFirst, output wordAddr, output wordData, output commit,
                   output peekAddr, input busy, input peekData);
    modport engine (input wordValid, input wordFirst, input wordAddr, input wordData, input commit,
                    input peekAddr, output busy, output peekData);
endinterface

// >>> hw/eeprom_prog_engine.sv
// Page buffer, programming cycle timer and the 512-byte storage array
module eeprom_prog_engine
    import eeprom_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    prog_if.engine port
);
    logic [BYTE_W-1:0] mem [MEM_DEPTH];
    logic [BYTE_W-1:0] pageBuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q;
    logic [PAGE_SEL_W-1:0] page_q;
    logic busy_q;
    logic [TIMER_W-1:0] timer_q;
    logic [BYTE_W-1:0] peek_q;
    logic progDone;

    localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(PROG_CYCLES - 1);

    assign progDone = busy_q && (timer_q == TIMER_ZERO);
    assign port.busy = busy_q;
    assign port.peekData = peek_q;

    // Collect page bytes; a first byte drops leftovers of an aborted write
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mask_q <= '0;
            page_q <= '0;
        end else if (clkEn) begin
            if (progDone) begin
                mask_q <= '0;
            end else if (port.wordValid && !busy_q) begin
                page_q <= port.wordAddr[MEM_ADDR_W-1:NIBBLE_W];
                if (port.wordFirst) begin
                    mask_q <= PAGE_BYTES'(1) << port.wordAddr[NIBBLE_W-1:0];
                end else begin
                    mask_q <= mask_q | (PAGE_BYTES'(1) << port.wordAddr[NIBBLE_W-1:0]);
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clkEn && port.wordValid && !busy_q) begin
            pageBuf[port.wordAddr[NIBBLE_W-1:0]] <= port.wordData;
        end
    end

    // Programming cycle, started by the stop that ends a write
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busy_q <= 1'h0;
            timer_q <= TIMER_ZERO;
        end else if (clkEn) begin
            if (port.commit && !busy_q && (mask_q != '0)) begin
                busy_q <= 1'h1;
                timer_q <= TIMER_LOAD;
            end else if (progDone) begin
                busy_q <= 1'h0;
            end else if (busy_q) begin
                timer_q <= timer_q - 1'h1;
            end
        end
    end

    // Array holds no reset; all collected bytes land on the last timer cycle
    always_ff @(posedge clk_sys) begin
        if (clkEn && progDone) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (mask_q[i]) begin
                    mem[{page_q, NIBBLE_W'(i)}] <= pageBuf[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            peek_q <= '0;
        end else if (clkEn) begin
            peek_q <= mem[port.peekAddr];
        end
    end
endmodule // eeprom_prog_engine

// >>> hw/eeprom_two_wire_slave.sv
// Two-wire slave front end of the byte-programmable EEPROM, write path
//
// Behaviour
// - Data falling while clock high is detected as a start.
// - Data rising while clock high is detected as a stop.
// - Data sampled on clock high; data change during clock high is start or stop.
// - Data line changes only while clock low, except master start and stop.
// - Respond only when select bits 7:2 equal the fixed pattern.
// - Select bit 1 is the ninth, top address bit.
// - Select bit 0 zero means write, one means read.
// - Matching select byte is acknowledged in the next bit slot.
// - Acknowledge holds data low through the acknowledge clock-high time.
// - Not-acknowledge leaves data released, pulled high.
// - One write carries at most sixteen bytes within one aligned page.
// - After select ack, next byte loads the address counter and is acknowledged.
// - Each data byte bumps only the low address nibble and is acknowledged.
// - Stop ending a write starts the programming cycle.
// - While programming, write select is not acknowledged; master polls.
module eeprom_two_wire_slave
    import eeprom_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic linkClk,
    input wire logic memorySerialClockLine,
    input wire logic memorySerialDataLineIn,
    output logic memorySerialDataLineOut,
    output logic memorySerialDataLineOe,
    output logic progBusy,
    input wire logic [MEM_ADDR_W-1:0] peekAddr,
    output logic [BYTE_W-1:0] peekData
);
    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_SELECT   = 8'h02,
        ST_SEL_ACK  = 8'h04,
        ST_ADDR     = 8'h08,
        ST_ADDR_ACK = 8'h10,
        ST_DATA     = 8'h20,
        ST_DATA_ACK = 8'h40,
        ST_IGNORE   = 8'h80
    } link_state_e;

    function automatic logic selectMatches(input logic [BYTE_W-1:0] b);
        return b[SEL_FIELD_MSB:SEL_FIELD_LSB] == FIXED_DEVICE_ADDRESS_FIELD;
    endfunction

    function automatic logic [BYTE_W-1:0] bumpLowNibble(input logic [BYTE_W-1:0] a);
        return {a[BYTE_W-1:NIBBLE_W], a[NIBBLE_W-1:0] + NIBBLE_ONE};
    endfunction

    prog_if progBus ();

    // ---------------- Link clock domain ----------------
    logic linkRstMeta_q, linkRst_q;
    logic ceMeta_q, ceSync_q;
    logic busyMeta_q, busySync_q;
    logic sclMeta_q, sclSync_q, sclPrev_q;
    logic sdaMeta_q, sdaSync_q, sdaPrev_q;
    logic sclRise, sclFall, startSeen, stopSeen;
    link_state_e state_q;
    logic [3:0] bitCnt_q;
    logic [BYTE_W-1:0] shift_q;
    logic byteDone;
    logic pageBit_q;
    logic dirWrite_q;
    logic [BYTE_W-1:0] addrCnt_q;
    logic firstPending_q, dataSent_q;
    logic sdaOe_q, sdaOut_q;
    logic dataTgl_q, commitTgl_q;
    logic xferFirst_q;
    logic [MEM_ADDR_W-1:0] xferAddr_q;
    logic [BYTE_W-1:0] xferData_q;
    logic ackSelect, ackState, recvState;

    // Reset and clock enable reach the link side through two flops
    always_ff @(posedge linkClk) begin
        linkRstMeta_q <= sys_rst;
        linkRst_q <= linkRstMeta_q;
        ceMeta_q <= clkEn;
        ceSync_q <= ceMeta_q;
        busyMeta_q <= progBus.busy;
        busySync_q <= busyMeta_q;
    end

    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            sclMeta_q <= 1'h1;
            sclSync_q <= 1'h1;
            sclPrev_q <= 1'h1;
            sdaMeta_q <= 1'h1;
            sdaSync_q <= 1'h1;
            sdaPrev_q <= 1'h1;
        end else if (ceSync_q) begin
            sclMeta_q <= memorySerialClockLine;
            sclSync_q <= sclMeta_q;
            sclPrev_q <= sclSync_q;
            sdaMeta_q <= memorySerialDataLineIn;
            sdaSync_q <= sdaMeta_q;
            sdaPrev_q <= sdaSync_q;
        end
    end

    // Edges only from the second and third stages
    assign sclRise = sclSync_q && !sclPrev_q;
    assign sclFall = !sclSync_q && sclPrev_q;
    assign startSeen = sclSync_q && sclPrev_q && !sdaSync_q && sdaPrev_q;
    assign stopSeen = sclSync_q && sclPrev_q && sdaSync_q && !sdaPrev_q;

    assign recvState = (state_q == ST_SELECT) || (state_q == ST_ADDR) || (state_q == ST_DATA);
    assign ackState = (state_q == ST_SEL_ACK) || (state_q == ST_ADDR_ACK) || (state_q == ST_DATA_ACK);
    assign byteDone = recvState && sclFall && (bitCnt_q == BITS_PER_BYTE);
    // Write select is withheld while a page is still programming
    assign ackSelect = selectMatches(shift_q) && !(shift_q[SEL_DIR_BIT] == DIR_WRITE && busySync_q);

    // Byte sequencing
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            state_q <= ST_IDLE;
        end else if (ceSync_q) begin
            if (startSeen) begin
                state_q <= ST_SELECT;
            end else if (stopSeen) begin
                state_q <= ST_IDLE;
            end else begin
                case (state_q)
                    ST_SELECT: begin
                        if (byteDone) begin
                            state_q <= ackSelect ? ST_SEL_ACK : ST_IGNORE;
                        end
                    end
                    ST_SEL_ACK: begin
                        if (sclFall) begin
                            // Reads are not served here: released line, ignored till next start
                            state_q <= dirWrite_q ? ST_ADDR : ST_IGNORE;
                        end
                    end
                    ST_ADDR: begin
                        if (byteDone) begin
                            state_q <= ST_ADDR_ACK;
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (sclFall) begin
                            state_q <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (byteDone) begin
                            state_q <= ST_DATA_ACK;
                        end
                    end
                    ST_DATA_ACK: begin
                        if (sclFall) begin
                            state_q <= ST_DATA;
                        end
                    end
                    ST_IDLE, ST_IGNORE: begin
                        state_q <= state_q;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Direction as captured with the select byte
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            dirWrite_q <= 1'h1;
            pageBit_q <= 1'h0;
        end else if (ceSync_q && byteDone && state_q == ST_SELECT) begin
            dirWrite_q <= (shift_q[SEL_DIR_BIT] == DIR_WRITE);
            pageBit_q <= shift_q[SEL_PAGE_BIT];
        end
    end

    // Bit shifting: sample on the clock rise, count restarts on start
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            bitCnt_q <= BIT_CNT_ZERO;
            shift_q <= '0;
        end else if (ceSync_q) begin
            if (startSeen || stopSeen) begin
                bitCnt_q <= BIT_CNT_ZERO;
            end else if (ackState && sclFall) begin
                bitCnt_q <= BIT_CNT_ZERO;
            end else if (recvState && sclRise && bitCnt_q != BITS_PER_BYTE) begin
                shift_q <= {shift_q[BYTE_W-2:0], sdaSync_q};
                bitCnt_q <= bitCnt_q + BIT_CNT_ONE;
            end
        end
    end

    // Acknowledge drive: taken up on a clock fall, let go on a clock fall or on a start or stop
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            sdaOe_q <= 1'h0;
            sdaOut_q <= 1'h0;
        end else if (ceSync_q) begin
            sdaOut_q <= 1'h0;
            if (startSeen || stopSeen) begin
                sdaOe_q <= 1'h0;
            end else if (byteDone) begin
                sdaOe_q <= (state_q == ST_SELECT) ? ackSelect : 1'h1;
            end else if (ackState && sclFall) begin
                sdaOe_q <= 1'h0;
            end
        end
    end

    // Address counter: full load, then low nibble only
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            addrCnt_q <= '0;
            firstPending_q <= 1'h0;
            dataSent_q <= 1'h0;
        end else if (ceSync_q) begin
            if (startSeen) begin
                dataSent_q <= 1'h0;
                firstPending_q <= 1'h0;
            end else if (byteDone && state_q == ST_ADDR) begin
                addrCnt_q <= shift_q;
                firstPending_q <= 1'h1;
            end else if (byteDone && state_q == ST_DATA) begin
                addrCnt_q <= bumpLowNibble(addrCnt_q);
                firstPending_q <= 1'h0;
                dataSent_q <= 1'h1;
            end
        end
    end

    // Words cross by toggle; fields stay still for a whole byte time after each toggle
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            dataTgl_q <= 1'h0;
            commitTgl_q <= 1'h0;
            xferFirst_q <= 1'h0;
            xferAddr_q <= '0;
            xferData_q <= '0;
        end else if (ceSync_q) begin
            if (byteDone && state_q == ST_DATA) begin
                xferFirst_q <= firstPending_q;
                xferAddr_q <= {pageBit_q, addrCnt_q};
                xferData_q <= shift_q;
                dataTgl_q <= !dataTgl_q;
            end
            if (stopSeen && dataSent_q && (state_q == ST_DATA || state_q == ST_DATA_ACK)) begin
                commitTgl_q <= !commitTgl_q;
            end
        end
    end

    // ---------------- System clock domain ----------------
    logic dataMeta_q, dataSync_q, dataPrev_q;
    logic commitMeta_q, commitSync_q, commitPrev_q;
    logic wordValid_q, wordFirst_q, commit_q;
    logic [MEM_ADDR_W-1:0] wordAddr_q;
    logic [BYTE_W-1:0] wordData_q;
    logic busyOut_q;
    logic [BYTE_W-1:0] peekOut_q;
    logic [MEM_ADDR_W-1:0] peekAddr_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dataMeta_q <= 1'h0;
            dataSync_q <= 1'h0;
            dataPrev_q <= 1'h0;
            commitMeta_q <= 1'h0;
            commitSync_q <= 1'h0;
            commitPrev_q <= 1'h0;
        end else if (clkEn) begin
            dataMeta_q <= dataTgl_q;
            dataSync_q <= dataMeta_q;
            dataPrev_q <= dataSync_q;
            commitMeta_q <= commitTgl_q;
            commitSync_q <= commitMeta_q;
            commitPrev_q <= commitSync_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wordValid_q <= 1'h0;
            wordFirst_q <= 1'h0;
            wordAddr_q <= '0;
            wordData_q <= '0;
            commit_q <= 1'h0;
        end else if (clkEn) begin
            wordValid_q <= dataSync_q ^ dataPrev_q;
            commit_q <= commitSync_q ^ commitPrev_q;
            if (dataSync_q ^ dataPrev_q) begin
                wordFirst_q <= xferFirst_q;
                wordAddr_q <= xferAddr_q;
                wordData_q <= xferData_q;
            end
        end
    end

    assign progBus.wordValid = wordValid_q;
    assign progBus.wordFirst = wordFirst_q;
    assign progBus.wordAddr = wordAddr_q;
    assign progBus.wordData = wordData_q;
    assign progBus.commit = commit_q;
    assign progBus.peekAddr = peekAddr_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busyOut_q <= 1'h0;
            peekOut_q <= '0;
            peekAddr_q <= '0;
        end else if (clkEn) begin
            busyOut_q <= progBus.busy;
            peekOut_q <= progBus.peekData;
            peekAddr_q <= peekAddr;
        end
    end

    eeprom_prog_engine #(
        .PROG_CYCLES(PROG_CYCLES)
    ) engine (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .port(progBus.engine)
    );

    // Clock line is input only
    assign memorySerialDataLineOut = sdaOut_q;
    assign memorySerialDataLineOe = sdaOe_q;
    assign progBusy = busyOut_q;
    assign peekData = peekOut_q;
endmodule // eeprom_two_wire_slave

// >>> verification/two_wire_master.sv
// Behavioural two-wire bus master that drives the EEPROM slave
module two_wire_master #(
    parameter int Q = 128
) (
    output logic scl,
    output logic sdaLow,
    input wire logic sdaWire
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus: clock stands high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // Data moves only in the clock-low half; sampled mid-high
    task automatic clockBit(input logic b, output logic seen);
        sdaLow = !b;
        #Q;
        scl = 1'b1;
        #Q;
        seen = sdaWire;
        #Q;
        scl = 1'b0;
        #Q;
    endtask

    task automatic startCond();
        sdaLow = 1'b0;
        #Q;
        scl = 1'b1;
        #Q;
        sdaLow = 1'b1;
        #Q;
        scl = 1'b0;
        #Q;
    endtask

    // Long bus-free time after stop so the slave settles before a new start
    task automatic stopCond();
        sdaLow = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sdaLow = 1'b0;
        #(4 * Q);
    endtask

    // Select byte always first after a start is the caller's duty
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clockBit(b[i], s);
        end
        clockBit(1'b1, s);
        ack = !s;
    endtask

    task automatic recoverBus();
        logic s;
        s = 1'b0;
        for (int i = 0; i < 9 && !s; i++) begin
            clockBit(1'b1, s);
        end
        startCond();
    endtask
endmodule // two_wire_master

// >>> verification/eeprom_two_wire_slave_sva.sv
// Concurrent checks on the ports of the two-wire EEPROM slave
module eeprom_two_wire_slave_sva
    import eeprom_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic linkClk,
    input wire logic memorySerialClockLine,
    input wire logic memorySerialDataLineIn,
    input wire logic memorySerialDataLineOut,
    input wire logic memorySerialDataLineOe,
    input wire logic progBusy,
    input wire logic [MEM_ADDR_W-1:0] peekAddr,
    input wire logic [BYTE_W-1:0] peekData
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] busyLen_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !progBusy) begin
            busyLen_q <= 16'h0000;
        end else begin
            busyLen_q <= busyLen_q + 16'h0001;
        end
    end

    property p_open_drain;
        @(posedge clk_sys) disable iff (sys_rst) memorySerialDataLineOut == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");

    // Clock settled high for five link samples: data must hold
    property p_oe_steady_high;
        @(posedge linkClk) disable iff (sys_rst)
        memorySerialClockLine [*5] |-> $stable(memorySerialDataLineOe);
    endproperty
    a_oe_steady_high: assert property (p_oe_steady_high) else $error("data moved in clock high");

    property p_oe_rise_low;
        @(posedge linkClk) disable iff (sys_rst) $rose(memorySerialDataLineOe) |-> !memorySerialClockLine;
    endproperty
    a_oe_rise_low: assert property (p_oe_rise_low) else $error("ack began in clock high");

    property p_ack_held;
        @(posedge linkClk) disable iff (sys_rst) $rose(memorySerialDataLineOe) |-> memorySerialDataLineOe [*6];
    endproperty
    a_ack_held: assert property (p_ack_held) else $error("ack too short");

    property p_busy_len;
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(progBusy) |-> busyLen_q >= PROG_CYCLES - 1 && busyLen_q <= PROG_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("programming time wrong");

    property p_no_ack_busy;
        @(posedge clk_sys) disable iff (sys_rst) progBusy |-> !memorySerialDataLineOe;
    endproperty
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while programming");

    // Programming starts only after a stop, so the bus is idle then
    property p_busy_after_stop;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(progBusy) |-> memorySerialClockLine && memorySerialDataLineIn;
    endproperty
    a_busy_after_stop: assert property (p_busy_after_stop) else $error("programming without stop");

    property p_reset_state;
        @(posedge clk_sys) disable iff (sys_rst) $fell(sys_rst) |-> !progBusy && peekData == 8'h00;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    c_prog: cover property (@(posedge clk_sys) $rose(progBusy));
    c_ack: cover property (@(posedge linkClk) $rose(memorySerialDataLineOe));
    c_poll: cover property (@(posedge clk_sys) progBusy && !memorySerialClockLine);
endmodule // eeprom_two_wire_slave_sva

bind eeprom_two_wire_slave eeprom_two_wire_slave_sva #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .linkClk(linkClk),
    .memorySerialClockLine(memorySerialClockLine), .memorySerialDataLineIn(memorySerialDataLineIn),
    .memorySerialDataLineOut(memorySerialDataLineOut), .memorySerialDataLineOe(memorySerialDataLineOe),
    .progBusy(progBusy), .peekAddr(peekAddr), .peekData(peekData));

// >>> verification/test_eeprom_two_wire_slave.sv
// Self-checking bench for the two-wire EEPROM slave write path
module test_eeprom_two_wire_slave
    import eeprom_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    // Long enough that the first poll is refused
    localparam int PROG_N = 3000;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic linkClk = 1'b0;
    logic [MEM_ADDR_W-1:0] peekAddr = 9'h000;
    logic [BYTE_W-1:0] peekData;
    logic mstScl, mstLow, devOut, devOe, progBusy;
    wire logic sdaWire;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    assign sdaWire = (mstLow || (devOe && !devOut)) ? 1'b0 : 1'b1;

    always #2 clk_sys = ~clk_sys;
    initial begin
        #0.7;
        forever #16 linkClk = ~linkClk;
    end

    eeprom_two_wire_slave #(.PROG_CYCLES(PROG_N)) eeprom_two_wire_slave_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .linkClk(linkClk),
        .memorySerialClockLine(mstScl), .memorySerialDataLineIn(sdaWire),
        .memorySerialDataLineOut(devOut), .memorySerialDataLineOe(devOe),
        .progBusy(progBusy), .peekAddr(peekAddr), .peekData(peekData));

    two_wire_master two_wire_master_inst (.scl(mstScl), .sdaLow(mstLow), .sdaWire(sdaWire));

    task automatic complete_run();
        $display("counts bad=%0d checked=%0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            $display("BAD t=%0t timeout", $time);
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s", $time, msg);
        end
    endtask

    task automatic ackByte(input logic [7:0] b, input logic exp, input string msg);
        logic ack;
        two_wire_master_inst.sendByte(b, ack);
        check({15'h0000, ack}, {15'h0000, exp}, msg);
    endtask

    task automatic peekCheck(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        peekAddr <= a;
        repeat (4) @(posedge clk_sys);
        #1;
        check({8'h00, peekData}, {8'h00, d}, "stored byte");
    endtask

    // Stop, then programming must start and polls be refused until done
    task automatic stopAndPoll();
        int n;
        logic ack;
        n = 0;
        ack = 1'b0;
        two_wire_master_inst.stopCond();
        check({15'h0000, progBusy}, 16'h0001, "programming not started");
        while (!ack && n < 20) begin
            two_wire_master_inst.startCond();
            two_wire_master_inst.sendByte(8'ha0, ack);
            two_wire_master_inst.stopCond();
            n++;
        end
        check(16'(n > 1), 16'h0001, "first poll acked");
        check({15'h0000, ack}, 16'h0001, "poll never acked");
        check({15'h0000, progBusy}, 16'h0000, "busy after poll ack");
    endtask

    task automatic writePage();
        two_wire_master_inst.startCond();
        ackByte(8'ha3 & 8'hfe, 1'b1, "upper write select");
        ackByte(8'h3e, 1'b1, "address byte");
        ackByte(8'h11, 1'b1, "data 0");
        ackByte(8'h22, 1'b1, "data 1");
        ackByte(8'h33, 1'b1, "data 2");
        stopAndPoll();
        peekCheck(9'h13e, 8'h11);
        peekCheck(9'h13f, 8'h22);
        peekCheck(9'h130, 8'h33);
        $display("test writePage done");
    endtask

    task automatic refuseSelect();
        logic [7:0] bad [4] = '{8'ha4, 8'ha8, 8'hb0, 8'h20};
        logic s;
        foreach (bad[i]) begin
            two_wire_master_inst.startCond();
            ackByte(bad[i], 1'b0, "foreign select acked");
            two_wire_master_inst.stopCond();
        end
        two_wire_master_inst.startCond();
        ackByte(8'ha1, 1'b1, "read select");
        for (int i = 0; i < 4; i++) begin
            two_wire_master_inst.clockBit(1'b1, s);
        end
        two_wire_master_inst.startCond();
        ackByte(8'ha0, 1'b1, "select after restart");
        ackByte(8'h07, 1'b1, "address after restart");
        two_wire_master_inst.stopCond();
        repeat (300) @(posedge clk_sys);
        check({15'h0000, progBusy}, 16'h0000, "programming with no data");
        $display("test refuseSelect done");
    endtask

    task automatic recoverBus();
        logic s;
        two_wire_master_inst.startCond();
        ackByte(8'ha0, 1'b1, "select before abort");
        two_wire_master_inst.clockBit(1'b0, s);
        two_wire_master_inst.clockBit(1'b1, s);
        two_wire_master_inst.recoverBus();
        ackByte(8'ha0, 1'b1, "select after recovery");
        ackByte(8'h05, 1'b1, "address after recovery");
        ackByte(8'h5a, 1'b1, "data after recovery");
        stopAndPoll();
        peekCheck(9'h005, 8'h5a);
        $display("test recoverBus done");
    endtask

    initial begin
        // Reset spans several link clock edges so both domains clear
        repeat (40) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (40) @(posedge clk_sys);
        writePage();
        refuseSelect();
        recoverBus();
        complete_run();
    end
endmodule // test_eeprom_two_wire_slave
